/* design/sptx_serial_in.sv */
// Purpose: deframes serial audio for the biphase encoder
// Assumes: serial clock, frame sync and data synchronous to ref_clk
// Notes:   serial clock is oversampled; edges detected from registers
//          a channel closes on the sync edge that starts the next one,
//          so the pair leaves only once the following left has begun
//          biphase clock is 128 per frame: oversampling by 3 or by 2
`timescale 1ns/1ps
`include "sptx_params.svh"
module sptx_serial_in
  import sptx_pkg::*;
#(
  // sample register width handed to the encoder
  parameter int SAMPLE_W = `SPTX_SAMPLE_W,
  // width of the bit slot counter
  parameter int SLOT_W   = `SPTX_SLOT_W
)
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // configuration
  input  wire sptx_pkg::sptx_align_t alignSel,
  input  wire sptx_pkg::sptx_width_t widthSel,
  input  wire sptx_pkg::sptx_ratio_t ratioSel,
  // serial audio from the signal routing unit
  input  wire logic                 serialClk,
  input  wire logic                 frameSync,
  input  wire logic                 serialData,
  // oversampling clock input, sampled
  input  wire logic                 oversamplingClockIn,
  // to the biphase encoder
  output logic [23:0]               leftSample,
  output logic [23:0]               rightSample,
  output logic                      pairValid,
  output logic                      biphaseTick
);
  import sptx_pkg::*;

  // the capture path is written for 24-bit sample registers
  if (SAMPLE_W != `SPTX_SAMPLE_W)
  begin : gBadSampleW
    $error("sample width must be 24");
  end
  // the slot counter must reach the last slot of a half frame
  if (SLOT_W != `SPTX_SLOT_W)
  begin : gBadSlotW
    $error("slot counter width must be 6");
  end

  // all state lives in one record: edge history of the sampled pins,
  // the bit slot and bit count of the open channel, the shift word,
  // the held left word and the registered outputs
  // edge history resets low, the idle level of the serial clock, so no
  // false rising edge follows reset
  typedef struct packed {
    logic        sclkPrev;
    logic        fsPrev;
    logic        osPrev;
    logic [5:0]  slot;
    logic [4:0]  got;
    logic [23:0] shift;
    logic [23:0] left;
    logic [23:0] leftOut;
    logic [23:0] rightOut;
    logic        valid;
    logic [8:0]  bpCnt;
    logic        tick;
  } sptx_state_t;

  sptx_state_t state_q;
  sptx_state_t state_d;

  function automatic logic [5:0] msbOffset(input sptx_align_t a,
                                           input sptx_width_t w);
    logic [5:0] o;
    o = `SPTX_LJ_OFS;
    if (a == SPTX_I2S)
      o = `SPTX_I2S_OFS;
    else if (a == SPTX_RJ)
    begin
      case (w)
        SPTX_W16: o = `SPTX_RJ_OFS_16;
        SPTX_W18: o = `SPTX_RJ_OFS_18;
        SPTX_W20: o = `SPTX_RJ_OFS_20;
        default:  o = `SPTX_RJ_OFS_24;
      endcase
    end
    return o;
  endfunction : msbOffset

  function automatic logic [4:0] wordLen(input sptx_width_t w);
    logic [4:0] n;
    case (w)
      SPTX_W16: n = `SPTX_LEN_16;
      SPTX_W18: n = `SPTX_LEN_18;
      SPTX_W20: n = `SPTX_LEN_20;
      default:  n = `SPTX_LEN_24;
    endcase
    return n;
  endfunction : wordLen

  // biphase clock is 128 per frame: top count of the divider
  function automatic logic [8:0] biphaseTop(input sptx_ratio_t r);
    logic [8:0] t;
    t = (r == SPTX_R384) ? `SPTX_BP_TOP_384 : `SPTX_BP_TOP_256;
    return t;
  endfunction : biphaseTop

  logic       sclkRise;
  logic       fsEdge;
  logic [5:0] ofs;
  logic [4:0] len;
  logic       isLeft;
  logic [5:0] curSlot;
  logic [8:0] divTop;
  logic [4:0] gotBase;

  assign sclkRise = serialClk & ~state_q.sclkPrev;
  assign ofs      = msbOffset(alignSel, widthSel);
  assign len      = wordLen(widthSel);
  assign divTop   = biphaseTop(ratioSel);

  always_comb
  begin
    state_d          = state_q;
    state_d.sclkPrev = serialClk;
    state_d.osPrev   = oversamplingClockIn;
    state_d.valid    = 1'b0;
    state_d.tick     = 1'b0;
    fsEdge           = 1'b0;
    curSlot          = state_q.slot;
    gotBase          = state_q.got;
    // I2S has sync low for left; the others high
    isLeft = (alignSel == SPTX_I2S) ? ~state_q.fsPrev : state_q.fsPrev;
    if (sclkRise)
    begin
      state_d.fsPrev = frameSync;
      fsEdge         = frameSync ^ state_q.fsPrev;
      // slot counts from the sync transition
      curSlot        = fsEdge ? 6'h00 : state_q.slot;
      gotBase        = fsEdge ? 5'h00 : state_q.got;
      if (fsEdge)
      begin
        state_d.got   = 5'h00;
        state_d.shift = '0;
      end
      state_d.slot = (curSlot == `SPTX_FRAME_HALF) ? curSlot
                                                   : curSlot + 6'h01;
      // capture window starts at the MSB offset
      // take exactly len bits per channel
      // slots past the word are ignored, so longer frames are harmless in LJ and I2S; RJ offsets assume 32 slots
      if (curSlot >= ofs && gotBase < len)
      begin
        state_d.got = gotBase + 5'h01;
        state_d.shift = (fsEdge ? 24'h000000 : state_q.shift) |
          ({23'h000000, serialData} << (`SPTX_MSB_POS - gotBase));
      end
      // a channel closes at the next sync edge
      if (fsEdge)
      begin
        if (isLeft)
          state_d.left = state_q.shift;
        else
        begin
          state_d.leftOut  = state_q.left;
          state_d.rightOut = state_q.shift;
          state_d.valid    = 1'b1;
        end
      end
    end
    // divide oversampling clock by ratio over 128
    // a ratio change wraps a high count at once, never a long gap
    if (oversamplingClockIn & ~state_q.osPrev)
    begin
      state_d.bpCnt = (state_q.bpCnt >= divTop) ? 9'h000
                                                : state_q.bpCnt + 9'h001;
      state_d.tick  = (state_q.bpCnt >= divTop);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign leftSample  = state_q.leftOut;
  assign rightSample = state_q.rightOut;
  assign pairValid   = state_q.valid;
  assign biphaseTick = state_q.tick;
endmodule : sptx_serial_in

/* design/sptx_params.svh */
// Purpose: constants for the serial audio input stage
// Assumes: included by the package and the design module
// Notes:   word lengths are bit counts, offsets are in serial clocks
`ifndef SPTX_PARAMS_SVH
`define SPTX_PARAMS_SVH
`define SPTX_SAMPLE_W      24
`define SPTX_SLOT_W        6
`define SPTX_FRAME_HALF    6'h1F
`define SPTX_RJ_OFS_16     6'h10
`define SPTX_RJ_OFS_18     6'h0E
`define SPTX_RJ_OFS_20     6'h0C
`define SPTX_RJ_OFS_24     6'h08
`define SPTX_LEN_16        5'h10
`define SPTX_LEN_18        5'h12
`define SPTX_LEN_20        5'h14
`define SPTX_LEN_24        5'h18
`define SPTX_I2S_OFS       6'h01
`define SPTX_LJ_OFS        6'h00
`define SPTX_BP_TOP_384    9'h002
`define SPTX_BP_TOP_256    9'h001
`define SPTX_MSB_POS       5'h17
`endif

/* design/sptx_pkg.sv */
// Purpose: types for the serial audio input stage
// Assumes: constants come from sptx_params.svh
// Notes:   none
`include "sptx_params.svh"
package sptx_pkg;
  typedef enum logic [1:0] {SPTX_LJ, SPTX_I2S, SPTX_RJ} sptx_align_t;
  typedef enum logic [1:0] {SPTX_W16, SPTX_W18, SPTX_W20, SPTX_W24}
    sptx_width_t;
  typedef enum logic {SPTX_R384, SPTX_R256} sptx_ratio_t;
endpackage : sptx_pkg

/* tb/sptx_serial_in_properties.sv */
// Purpose: port checks on the serial input stage
// Assumes: inputs keep the hand-over contract
// Notes:   bound after endmodule
`timescale 1ns/1ps
module sptx_serial_in_chk
  import sptx_pkg::*;
(
  input wire logic ref_clk, reset_n, serialClk, frameSync,
  input wire logic serialData, oversamplingClockIn,
  input wire sptx_pkg::sptx_align_t alignSel,
  input wire sptx_pkg::sptx_width_t widthSel,
  input wire sptx_pkg::sptx_ratio_t ratioSel,
  input wire logic [23:0] leftSample, rightSample,
  input wire logic pairValid, biphaseTick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic osPrev_q, seen_q;
  sptx_ratio_t ratioPrev_q;
  logic [2:0] rise_q;
  wire osRise = oversamplingClockIn & ~osPrev_q;
  // oversampling rises seen since the previous tick
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      {osPrev_q, seen_q, rise_q} <= '0;
      ratioPrev_q <= SPTX_R384;
    end
    else
    begin
      osPrev_q <= oversamplingClockIn;
      ratioPrev_q <= ratioSel;
      // a ratio change clears seen_q, so no count is checked until a whole interval has run
      seen_q <= (seen_q | biphaseTick) && ratioSel == ratioPrev_q;
      rise_q <= biphaseTick ? 3'(osRise) : rise_q + 3'(osRise);
    end
  pulse_once_a:
    assert property (pairValid |=> !pairValid) else $error("long pair");
  samples_hold_a:
    assert property (!pairValid |-> $stable({leftSample, rightSample}))
    else $error("samples moved");
  low_bits_a:
    assert property (pairValid && widthSel == SPTX_W16 |->
      {leftSample[7:0], rightSample[7:0]} == 16'h0000) else $error("low");
  pair_side_a:
    assert property (pairValid |-> $past(frameSync, 2) ==
      (alignSel != SPTX_I2S)) else $error("pair side");
  pair_clk_a:
    assert property (pairValid |-> $past(serialClk) && !$past(serialClk, 2)
      || $past(serialClk, 2) && !$past(serialClk, 3)) else $error("clk");
  tick_gap_a:
    assert property (biphaseTick |=> !biphaseTick [*3]) else $error("gap");
  tick_count_a:
    assert property (biphaseTick && seen_q |->
      rise_q == (ratioSel == SPTX_R384 ? 3'h3 : 3'h2))
    else $error("tick count");
  reset_clear_a:
    assert property ($rose(reset_n) |-> !pairValid && leftSample == 24'h0)
    else $error("reset");
  cover property (pairValid && alignSel == SPTX_RJ);
  cover property (pairValid && alignSel == SPTX_I2S);
  cover property (biphaseTick && ratioSel == SPTX_R256);
  cover property (pairValid && alignSel == SPTX_LJ && widthSel == SPTX_W16);
endmodule : sptx_serial_in_chk
bind sptx_serial_in sptx_serial_in_chk sptx_serial_in_chk_inst (.*);

/* tb/sptx_audio_src.sv */
// Purpose: serial audio source model
// Assumes: four ref_clk per serial slot
// Notes:   serial clock stands low between frames
`timescale 1ns/1ps
module sptx_audio_src
  import sptx_pkg::*;
(
  input wire logic ref_clk,
  output logic serialClk = 0, frameSync = 0, serialData = 0,
  output logic oversamplingClockIn = 0
);
  always @(posedge ref_clk) oversamplingClockIn <= ~oversamplingClockIn;
  // data moves only while the clock is low
  task automatic slot(input logic s, d);
    @(posedge ref_clk) {serialClk, frameSync, serialData} <= {1'b0, s, d};
    repeat (2) @(posedge ref_clk);
    serialClk <= 1'b1;
    @(posedge ref_clk);
  endtask : slot
  task automatic frame(input sptx_align_t a, input int len,
                       input logic [23:0] l, r);
    logic f;
    int ofs, b;
    logic [23:0] w;
    f = a != SPTX_I2S;
    ofs = a == SPTX_RJ ? 32 - len : int'(a == SPTX_I2S);
    slot(!f, ~serialData);
    for (int k = 0; k < 65; k++)
    begin
      b = k % 32 - ofs;
      w = k < 32 ? l : r;
      // outside the word the line toggles rather than holding
      slot(k < 32 || k == 64 ? f : !f,
           b >= 0 && b < len && k < 64 ? w[23 - b] : ~serialData);
    end
    @(posedge ref_clk) serialClk <= 1'b0;
  endtask : frame
endmodule : sptx_audio_src

/* tb/test_spdif_tx_serial_input.sv */
// Purpose: self-checking bench of the serial input stage
// Assumes: model source drives the serial side
// Notes:   none
`timescale 1ns/1ps
module test_spdif_tx_serial_input;
  import sptx_pkg::*;
  logic ref_clk = 0, reset_n = 0;
  sptx_align_t alignSel = SPTX_LJ;
  sptx_width_t widthSel = SPTX_W24;
  sptx_ratio_t ratioSel = SPTX_R384;
  wire serialClk, frameSync, serialData, oversamplingClockIn;
  wire [23:0] leftSample, rightSample;
  wire pairValid, biphaseTick;
  int n_errors = 0, samples_checked = 0, pairs = 0, ticks = 0;
  sptx_serial_in sptx_serial_in_inst (.*);
  sptx_audio_src sptx_audio_src_inst (.*);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pairs <= pairs + int'(pairValid === 1'b1);
  always @(posedge ref_clk) ticks <= ticks + int'(biphaseTick === 1'b1);
  task automatic check(input string n, input logic [23:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : check
  task automatic check_formats;
    int p, len;
    logic [23:0] m, l, r;
    for (int a = 0; a < 3; a++)
      for (int w = 3; w >= 0; w--)
      begin
        @(posedge ref_clk) alignSel <= sptx_align_t'(a);
        widthSel <= sptx_width_t'(w);
        len = w == 3 ? 24 : 16 + 2 * w;
        m = ~(24'hFFFFFF >> len);
        l = 24'hC35A96 ^ 24'(w);
        r = 24'h3CA569 ^ 24'(a << 4);
        p = pairs;
        sptx_audio_src_inst.frame(sptx_align_t'(a), len, l, r);
        // let the pair counter settle past the final pulse
        @(negedge ref_clk);
        // the lead-in slot is a short right channel that the first left sync edge closes: one extra pair
        check("pair count", 24'(p + 2), 24'(pairs));
        check("left", l & m, leftSample);
        check("right", r & m, rightSample);
      end
  endtask : check_formats
  task automatic check_ratio;
    int t;
    logic [23:0] e;
    for (int r = 0; r < 2; r++)
    begin
      @(posedge ref_clk) ratioSel <= sptx_ratio_t'(r);
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk) t = ticks;
      // 384 oversampling rises: 128 ticks at 384x, 192 at 256x
      e = r == 0 ? 24'h000080 : 24'h0000C0;
      repeat (768) @(posedge ref_clk);
      @(negedge ref_clk);
      check("ticks", e, 24'(ticks - t));
    end
  endtask : check_ratio
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    check_formats();
    check_ratio();
    report_and_stop();
  end
  // the run needs about 4750 clocks
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule : test_spdif_tx_serial_input
